/* inc/pcss_pkg.sv */
package pcss_pkg;
    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 3;          // Three flops per pin input
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;             // Clock rate in MHz
    localparam int CARD_RESET_NS = 1000;     // Card reset pulse length
    localparam int CARD_RESET_CYC = (CARD_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_NS = 80;            // Address setup before strobe
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_NS = 40;             // Hold after strobe release
    localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_NS = 160;          // Least strobe width
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    // Card answers one clock after the strobe, then three flops and the accept stage
    localparam int WAIT_SEE_CYC = SYNC_STAGES + 3;
    // Strobe lasts long enough for a wait from the card to reach the engine
    localparam int STROBE_LEN_CYC = (STROBE_CYC > WAIT_SEE_CYC) ? STROBE_CYC : WAIT_SEE_CYC;
    localparam int CNT_W = 8;                // Width of phase counter
    // ------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------
    localparam int UPPER_W = 3;              // Extra card address bits
    localparam int LOW_W = 23;               // Shared low address bits
    localparam int UPPER_LSB = 23;           // First extra address bit
    // ------------------------------------------------------------
    // Voltage sense codes (both lines low means 3.3 volt capable)
    // ------------------------------------------------------------
    localparam logic [1:0] VS_5V_ONLY = 2'h3;
    localparam logic [1:0] VS_LOW_OK = 2'h2;
    // ------------------------------------------------------------
    // Cycle states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PCSS_IDLE,
        PCSS_SETUP,
        PCSS_STROBE,
        PCSS_HOLD
    } pcss_state_e;
endpackage

/* rtl/pcss_socket.sv */
`timescale 1ns/10ps
module pcss_socket #(
    parameter int RESET_CYC = pcss_pkg::CARD_RESET_CYC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic CE,
    // Host request side
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_IO,
    input wire logic REQ_WRITE,
    input wire logic REQ_ATTR,
    input wire logic REQ_EVEN,
    input wire logic REQ_ODD,
    input wire logic [25:0] REQ_ADDR,
    output logic DONE,
    input wire logic PWR_REQ_ON,
    input wire logic PWR_REQ_VPP_VCC,
    input wire logic PWR_REQ_VPP_PGM,
    input wire logic CARD_RESET_REQ,
    // Status toward host
    output logic CARD_PRESENT,
    output logic CARD_LOW_VOLT,
    output logic POWERED,
    output logic WRITE_PROTECT,
    output logic IO_IS16,
    output logic CARD_READY,
    output logic CARD_IRQ,
    output logic BATT1_OK,
    output logic BATT2_OK,
    output logic STATUS_CHANGE,
    // Card pins
    input wire logic CARD_DETECT1_N,
    input wire logic CARD_DETECT2_N,
    input wire logic [1:0] VSENSE,
    input wire logic PROTECT_WIDTH_N,
    input wire logic READY_IRQ_N,
    input wire logic STRETCH_N,
    input wire logic BATT2_AUDIO,
    input wire logic BATT1_STATCHG_N,
    output logic SPACE_SEL_N,
    output logic SPACE_SEL_OE_N,
    output logic EVEN_EN_N,
    output logic ODD_EN_N,
    output logic MEM_RD_N,
    output logic MEM_WR_N,
    output logic IO_RD_N,
    output logic IO_WR_N,
    output logic STROBE_OE_N,
    output logic CARD_RESET,
    output logic PROG_FROM_CORE_SUPPLY,
    output logic PROG_HIGH_VOLTAGE,
    output logic SUPPLY_LOW_REQ_N,
    output logic SUPPLY_HIGH_REQ_N,
    output logic ADDR_BUF_EN_N,
    output logic DATA_BUF_EN_N,
    output logic [2:0] CARD_UPPER_ADDR
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Every card input arrives with no relation to our clock. Each one runs
    // through three flops, and a fourth stage takes a new level only once the
    // second and third stages agree, so a single glitch never reaches logic.
    // Cost: four edges of latency on every pin, wait included, which is why
    // the strobe phase is never shorter than that latency allows.
    // Reset fills the chain with ones, the idle level of every pin, so the
    // card looks absent and no false edge appears as reset ends.
    // All flops here serve this socket only; a second socket is a second copy
    localparam int NPIN = 9; // Number of asynchronous card inputs
    logic [NPIN-1:0] pin_raw; // Raw pin vector
    logic [NPIN-1:0] s1_r; // First stage, read only by s2_r
    logic [NPIN-1:0] s2_r; // Second stage
    logic [NPIN-1:0] s3_r; // Third stage
    logic [NPIN-1:0] pin_r; // Accepted level
    logic [NPIN-1:0] pin_nxt; // Accepted when stages two and three agree
    assign pin_raw = {CARD_DETECT1_N, CARD_DETECT2_N, VSENSE, PROTECT_WIDTH_N,
                      READY_IRQ_N, STRETCH_N, BATT2_AUDIO, BATT1_STATCHG_N};
    logic [NPIN-1:0] agree; // Stages two and three match, bit by bit
    assign agree = ~(s2_r ^ s3_r);
    // A bit moves only when the last two stages agree; otherwise it keeps its level
    assign pin_nxt = (s2_r & agree) | (pin_r & ~agree);
    // Pin shift chain; idle-high reset so a card looks absent
    always_ff @(posedge CLK) begin
        if (SRST) begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
            pin_r <= '1;
        end else if (CE) begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= pin_nxt;
        end
    end
    // Named synchronised pins
    wire cd1_n = pin_r[8];
    wire cd2_n = pin_r[7];
    wire [1:0] vs = pin_r[6:5];
    wire pw_n = pin_r[4];
    wire ri_n = pin_r[3];
    wire wait_n = pin_r[2];
    wire bvd2 = pin_r[1];
    wire bvd1 = pin_r[0];

    // ------------------------------------------------------------
    // Presence, power and status decode
    // ------------------------------------------------------------
    // Presence needs both detect pins, since they sit at opposite ends of
    // the connector and only a fully seated card grounds them both.
    // Shared status pins change meaning with the mode of the card. The mode
    // is that of the last cycle taken, so software must run one cycle in
    // the wanted mode before it trusts these outputs.
    // Limitation: no debounce beyond the synchroniser; a bouncing insert
    // may show a few short presence pulses, and power then drops each time.
    // Both detect pins must be low; a half-seated card counts as absent
    wire present = ~cd1_n & ~cd2_n;
    wire low_ok = (vs != pcss_pkg::VS_5V_ONLY);
    logic pwr_on_r; // Supply request currently applied
    logic low_sel_r; // Low voltage chosen at power up
    logic io_mode_r; // Mode of the card, latched per cycle
    assign CARD_PRESENT = present;
    assign CARD_LOW_VOLT = low_ok;
    assign POWERED = pwr_on_r;
    // Shared inputs take meaning from the mode
    assign WRITE_PROTECT = ~io_mode_r & ~pw_n;
    assign IO_IS16 = io_mode_r & ~pw_n;
    assign CARD_READY = ~io_mode_r & ~ri_n;
    assign CARD_IRQ = io_mode_r & ~ri_n;
    assign BATT2_OK = ~io_mode_r & bvd2;
    assign BATT1_OK = ~io_mode_r & bvd1;
    assign STATUS_CHANGE = io_mode_r & ~bvd1;

    // Supply requests follow the host while a card sits in the socket.
    // The voltage chosen at power up stays until power is dropped, so a
    // sense pin that flickers later can never swap the supply under load.
    // Program voltage gives way to the core supply path if both are asked,
    // which keeps the two supply switches from ever fighting.
    // Power is dropped at once when the card leaves
    wire pwr_nxt = PWR_REQ_ON & present;
    // Voltage choice is made only at power up, never while the card runs
    wire low_nxt = pwr_on_r ? low_sel_r : low_ok;
    // Power control flops
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pwr_on_r <= 1'b0;
            low_sel_r <= 1'b0;
        end else if (CE) begin
            pwr_on_r <= pwr_nxt;
            low_sel_r <= low_nxt;
        end
    end
    assign SUPPLY_LOW_REQ_N = ~(pwr_on_r & low_sel_r);
    assign SUPPLY_HIGH_REQ_N = ~(pwr_on_r & ~low_sel_r);
    assign PROG_FROM_CORE_SUPPLY = pwr_on_r & PWR_REQ_VPP_VCC;
    assign PROG_HIGH_VOLTAGE = pwr_on_r & PWR_REQ_VPP_PGM & ~PWR_REQ_VPP_VCC;

    // ------------------------------------------------------------
    // Card reset
    // ------------------------------------------------------------
    // The card is held in reset for a fixed count after every power rise
    // and after each host request. No cycle is accepted while it runs.
    // A request during the pulse restarts the count from the top.
    // The reset pin is gated by power so an unpowered card is never driven.
    logic [pcss_pkg::CNT_W-1:0] rst_cnt_r; // Reset cycles left
    logic [pcss_pkg::CNT_W-1:0] rst_cnt_nxt;
    wire pwr_rise = pwr_nxt & ~pwr_on_r; // Fresh power always resets the card
    assign rst_cnt_nxt = (pwr_rise | CARD_RESET_REQ) ? RESET_CYC[pcss_pkg::CNT_W-1:0] :
                         (rst_cnt_r != '0) ? rst_cnt_r - 1'b1 : rst_cnt_r;
    // Reset pulse counter
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rst_cnt_r <= '0;
        end else if (CE) begin
            rst_cnt_r <= rst_cnt_nxt;
        end
    end
    assign CARD_RESET = pwr_on_r & (rst_cnt_r != '0);

    // ------------------------------------------------------------
    // Cycle engine
    // ------------------------------------------------------------
    // One cycle runs setup, strobe and hold, each from a shared down counter.
    // Setup lets the address and enables settle before any strobe falls.
    // The strobe phase waits for the synchronised wait pin to read high; it
    // is padded to the pin latency so a card that answers one clock after
    // the strobe falls is always seen in time.
    // Hold keeps address and enables after the strobe rises.
    // Losing the card or power abandons the cycle at once; no done follows,
    // so the host must treat a missing done as a failed access.
    pcss_pkg::pcss_state_e st_r, st_nxt; // Cycle phase
    logic [pcss_pkg::CNT_W-1:0] cnt_r, cnt_nxt; // Phase counter
    logic wr_r, attr_r, even_r, odd_r; // Latched request fields
    logic [25:0] addr_r; // Latched address
    wire usable = present & pwr_on_r & (rst_cnt_r == '0);
    wire cnt_zero = (cnt_r == '0);
    wire take = REQ_VALID & REQ_READY;
    assign REQ_READY = (st_r == pcss_pkg::PCSS_IDLE) & usable;
    // Next-phase decode
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_zero ? cnt_r : cnt_r - 1'b1;
        unique case (st_r)
            pcss_pkg::PCSS_IDLE: begin
                if (take) begin
                    st_nxt = pcss_pkg::PCSS_SETUP;
                    cnt_nxt = pcss_pkg::CNT_W'(pcss_pkg::SETUP_CYC - 1);
                end
            end
            pcss_pkg::PCSS_SETUP: begin
                if (cnt_zero) begin
                    st_nxt = pcss_pkg::PCSS_STROBE;
                    // Long enough for a wait from the card to pass the synchroniser
                    cnt_nxt = pcss_pkg::CNT_W'(pcss_pkg::STROBE_LEN_CYC - 1);
                end
            end
            pcss_pkg::PCSS_STROBE: begin
                // Stay while the card stretches the cycle
                if (cnt_zero & wait_n) begin
                    st_nxt = pcss_pkg::PCSS_HOLD;
                    cnt_nxt = pcss_pkg::CNT_W'(pcss_pkg::HOLD_CYC - 1);
                end
            end
            pcss_pkg::PCSS_HOLD: begin
                if (cnt_zero) begin
                    st_nxt = pcss_pkg::PCSS_IDLE;
                end
            end
            default: st_nxt = pcss_pkg::PCSS_IDLE;
        endcase
        // Card pulled mid cycle: abandon at once, strobes drop
        if (!usable) begin
            st_nxt = pcss_pkg::PCSS_IDLE;
        end
    end
    // Cycle state flops
    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_r <= pcss_pkg::PCSS_IDLE;
            cnt_r <= '0;
        end else if (CE) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    // Request fields are held for the whole cycle, so the host may change
    // its inputs as soon as the request is taken.
    // Request capture
    always_ff @(posedge CLK) begin
        if (SRST) begin
            io_mode_r <= 1'b0;
            wr_r <= 1'b0;
            attr_r <= 1'b0;
            even_r <= 1'b0;
            odd_r <= 1'b0;
            addr_r <= '0;
        end else if (CE && take) begin
            io_mode_r <= REQ_IO;
            wr_r <= REQ_WRITE;
            attr_r <= REQ_ATTR;
            even_r <= REQ_EVEN;
            odd_r <= REQ_ODD;
            addr_r <= REQ_ADDR;
        end
    end
    // Done pulse in the cycle after the last hold cycle
    logic done_r;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            done_r <= 1'b0;
        end else if (CE) begin
            done_r <= (st_r == pcss_pkg::PCSS_HOLD) & cnt_zero & usable;
        end
    end
    assign DONE = done_r;

    // ------------------------------------------------------------
    // Card pin drive
    // ------------------------------------------------------------
    // Strobes are active low and fall only in the strobe phase, which
    // keeps read and write from ever overlapping on the card.
    // Enables and the address buffer cover the whole cycle. The data
    // buffer opens for the whole of a write, so data settles before the
    // strobe, but only during the strobe of a read, so the card never
    // fights our drivers while its outputs are turning on.
    // Output enables float the shared lines when no usable card is there.
    wire busy = (st_r != pcss_pkg::PCSS_IDLE);
    wire strobe = (st_r == pcss_pkg::PCSS_STROBE);
    assign SPACE_SEL_N = io_mode_r ? 1'b0 : ~attr_r;
    assign EVEN_EN_N = ~(busy & even_r);
    assign ODD_EN_N = ~(busy & odd_r);
    assign MEM_RD_N = ~(strobe & ~io_mode_r & ~wr_r);
    assign MEM_WR_N = ~(strobe & ~io_mode_r & wr_r);
    assign IO_RD_N = ~(strobe & io_mode_r & ~wr_r);
    assign IO_WR_N = ~(strobe & io_mode_r & wr_r);
    // Tristate control lines when no usable card
    assign SPACE_SEL_OE_N = ~usable;
    assign STROBE_OE_N = ~usable;
    assign ADDR_BUF_EN_N = ~busy;
    assign DATA_BUF_EN_N = ~(busy & (wr_r | strobe));
    assign CARD_UPPER_ADDR = addr_r[pcss_pkg::UPPER_LSB +: pcss_pkg::UPPER_W];
endmodule // pcss_socket

/* verification/pcss_card_model.sv */
`timescale 1ns/10ps
module pcss_card_model (
    input wire logic CLK,
    input wire logic INS,
    input wire logic [4:0] WLEN,
    input wire logic MEM_RD_N,
    input wire logic MEM_WR_N,
    input wire logic IO_RD_N,
    input wire logic IO_WR_N,
    output logic CARD_DETECT1_N,
    output logic CARD_DETECT2_N,
    output logic STRETCH_N
);
    logic strobe_r = 1'h0;
    logic [4:0] wait_r = 5'h0; // Wait cycles left
    wire strobe = !(MEM_RD_N && MEM_WR_N && IO_RD_N && IO_WR_N);
    assign CARD_DETECT1_N = !INS;
    assign CARD_DETECT2_N = !INS;
    // Wait line is pulled up, so released it reads high
    assign STRETCH_N = (wait_r == 5'h0);
    // Hold wait low from each strobe start
    always_ff @(posedge CLK) begin
        strobe_r <= strobe;
        if (strobe && !strobe_r) begin
            wait_r <= WLEN;
        end else if (wait_r != 5'h0) begin
            wait_r <= wait_r - 5'h1;
        end
    end
endmodule // pcss_card_model

/* verification/pcss_socket_checker.sv */
`timescale 1ns/10ps
module pcss_socket_checker (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input wire logic REQ_IO,
    input wire logic REQ_WRITE,
    input wire logic REQ_ATTR,
    input wire logic REQ_EVEN,
    input wire logic REQ_ODD,
    input wire logic [25:0] REQ_ADDR,
    input wire logic DONE,
    input wire logic CARD_PRESENT,
    input wire logic STRETCH_N,
    input wire logic SPACE_SEL_N,
    input wire logic EVEN_EN_N,
    input wire logic ODD_EN_N,
    input wire logic MEM_RD_N,
    input wire logic MEM_WR_N,
    input wire logic IO_RD_N,
    input wire logic IO_WR_N,
    input wire logic ADDR_BUF_EN_N,
    input wire logic DATA_BUF_EN_N,
    input wire logic [2:0] CARD_UPPER_ADDR
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    // ----------------------------------------
    // Accepted request; checks look mid-strobe
    // ----------------------------------------
    sequence s_take;
        REQ_VALID && REQ_READY;
    endsequence
    a_attr_select: assert property (s_take ##0 !REQ_IO |-> ##5 SPACE_SEL_N == !$past(REQ_ATTR, 5))
        else $error("space select wrong");
    a_io_space: assert property (s_take ##0 REQ_IO |-> ##5 !SPACE_SEL_N)
        else $error("space select not low in io");
    a_lane_enable: assert property (s_take |-> ##5 {EVEN_EN_N, ODD_EN_N} == ~$past({REQ_EVEN, REQ_ODD}, 5))
        else $error("lane enables wrong");
    a_mem_strobe: assert property (s_take ##0 !REQ_IO |-> ##5 {MEM_RD_N, MEM_WR_N, IO_RD_N, IO_WR_N} == {$past(REQ_WRITE, 5), !$past(REQ_WRITE, 5), 2'h3})
        else $error("memory strobe wrong");
    a_io_strobe: assert property (s_take ##0 REQ_IO |-> ##5 {MEM_RD_N, MEM_WR_N, IO_RD_N, IO_WR_N} == {2'h3, $past(REQ_WRITE, 5), !$past(REQ_WRITE, 5)})
        else $error("io strobe wrong");
    // Long wait: the cycle must still be open
    a_stretch_hold: assert property (!STRETCH_N [*8] |-> !DONE)
        else $error("cycle ended during wait");
    a_addr_buf: assert property (s_take |-> ##2 !ADDR_BUF_EN_N [*5])
        else $error("address buffer off");
    a_data_buf: assert property (s_take |-> ##5 !DATA_BUF_EN_N)
        else $error("data buffer off");
    a_upper_addr: assert property (s_take |-> ##5 CARD_UPPER_ADDR == $past(REQ_ADDR[25:23], 5))
        else $error("upper address wrong");
    a_no_card: assert property (!CARD_PRESENT [*3] |-> &{MEM_RD_N, MEM_WR_N, IO_RD_N, IO_WR_N})
        else $error("strobe with no card");
endmodule // pcss_socket_checker

/* verification/pcss_socket_tb.sv */
`timescale 1ns/10ps
module pcss_socket_tb;
    logic CLK = 0, SRST = 1, CE = 1, REQ_VALID = 0, REQ_IO = 0, REQ_WRITE = 0, REQ_ATTR = 0;
    logic REQ_EVEN = 0, REQ_ODD = 0, PWR_REQ_ON = 0, PWR_REQ_VPP_VCC = 0, PWR_REQ_VPP_PGM = 0;
    logic CARD_RESET_REQ = 0, INS = 1, PROTECT_WIDTH_N = 0, READY_IRQ_N = 0;
    logic BATT2_AUDIO = 1, BATT1_STATCHG_N = 1;
    logic [25:0] REQ_ADDR = 26'h0;
    logic [1:0] VSENSE = 2'h3;
    logic [4:0] WLEN = 5'h0;
    logic REQ_READY, DONE, CARD_PRESENT, CARD_LOW_VOLT, POWERED, WRITE_PROTECT, IO_IS16;
    logic CARD_READY, CARD_IRQ, BATT1_OK, BATT2_OK, STATUS_CHANGE, SPACE_SEL_N, SPACE_SEL_OE_N;
    logic EVEN_EN_N, ODD_EN_N, MEM_RD_N, MEM_WR_N, IO_RD_N, IO_WR_N, STROBE_OE_N, CARD_RESET;
    logic PROG_FROM_CORE_SUPPLY, PROG_HIGH_VOLTAGE, SUPPLY_LOW_REQ_N, SUPPLY_HIGH_REQ_N;
    logic ADDR_BUF_EN_N, DATA_BUF_EN_N, CARD_DETECT1_N, CARD_DETECT2_N, STRETCH_N;
    logic [2:0] CARD_UPPER_ADDR;
    int mismatches = 0, checked = 0;
    // Cycles in setup, padded strobe and hold; done rises on the edge that ends these
    localparam int CYC_LEN = pcss_pkg::SETUP_CYC + pcss_pkg::STROBE_LEN_CYC + pcss_pkg::HOLD_CYC;
    always #20 CLK = ~CLK;
    pcss_socket #(.RESET_CYC(2)) dut_u (.*);
    pcss_card_model card_u (.*);
    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'h1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // Every wait loop gives up here
    task automatic limit(input int n);
        if (n >= 60) begin
            mismatches++;
            final_report;
        end
    endtask
    // Wait for ready, noting any card reset seen on the way
    task automatic wait_ready(output logic seen);
        int n = 0;
        seen = 1'h0;
        do begin
            @(posedge CLK);
            #1;
            n++;
            limit(n);
            seen |= (CARD_RESET === 1'h1);
        end while (REQ_READY !== 1'h1 || n < 5);
    endtask
    task automatic t_power;
        logic s;
        PWR_REQ_ON <= 1'h1;
        wait_ready(s);
        chk(s, "no reset at power up");
        chk(CARD_PRESENT === 1'h1, "card not present");
        chk({SUPPLY_HIGH_REQ_N, SUPPLY_LOW_REQ_N} === 2'h1, "supply request");
        @(posedge CLK);
        CARD_RESET_REQ <= 1'h1;
        @(posedge CLK);
        CARD_RESET_REQ <= 1'h0;
        wait_ready(s);
        chk(s, "no reset on request");
        $display("test power done");
    endtask
    task automatic cyc(input logic io, input logic wr, input logic at, input logic [4:0] st);
        int n = 0;
        @(posedge CLK);
        WLEN <= st;
        REQ_IO <= io;
        REQ_WRITE <= wr;
        REQ_ATTR <= at;
        REQ_EVEN <= 1'h1;
        REQ_ODD <= wr;
        REQ_ADDR <= {io, wr, at, 23'h0};
        REQ_VALID <= 1'h1;
        // Ready comes from flops only, so its mid-cycle level holds at the next edge
        do begin
            @(negedge CLK);
            n++;
            limit(n);
        end while (REQ_READY !== 1'h1);
        @(posedge CLK);
        REQ_VALID <= 1'h0;
        n = 0;
        do begin
            @(posedge CLK);
            #1;
            n++;
            limit(n);
            if (n == 4) begin
                chk({MEM_RD_N, MEM_WR_N, IO_RD_N, IO_WR_N} === ~(4'h8 >> {io, wr}), "strobe");
                chk(SPACE_SEL_N === (!io && !at), "space select");
                chk({EVEN_EN_N, ODD_EN_N} === {1'h0, !wr}, "lanes");
                chk({ADDR_BUF_EN_N, DATA_BUF_EN_N} === 2'h0, "buffers");
                chk(CARD_UPPER_ADDR === {io, wr, at}, "upper address");
            end
        end while (DONE !== 1'h1);
        chk((st == 5'h0) ? (n == CYC_LEN) : (n > CYC_LEN), "cycle length");
        chk(io ? (IO_IS16 & CARD_IRQ) : (WRITE_PROTECT & CARD_READY), "status");
        chk(io ? !(BATT2_OK | BATT1_OK | STATUS_CHANGE) : (BATT2_OK & BATT1_OK & !STATUS_CHANGE), "battery");
        $display("test cycle done");
    endtask
    task automatic t_vpp;
        int n = 0;
        @(posedge CLK);
        PWR_REQ_VPP_VCC <= 1'h1;
        do begin
            @(posedge CLK);
            n++;
            limit(n);
        end while (PROG_FROM_CORE_SUPPLY !== 1'h1);
        chk(PROG_HIGH_VOLTAGE === 1'h0, "vpp from vcc");
        PWR_REQ_VPP_VCC <= 1'h0;
        PWR_REQ_VPP_PGM <= 1'h1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
            limit(n);
        end while (PROG_HIGH_VOLTAGE !== 1'h1);
        chk(PROG_FROM_CORE_SUPPLY === 1'h0, "program voltage");
        $display("test vpp done");
    endtask
    task automatic t_remove;
        int n = 0;
        @(posedge CLK);
        INS <= 1'h0;
        do begin
            @(posedge CLK);
            #1;
            n++;
            limit(n);
        end while (CARD_PRESENT !== 1'h0);
        chk(REQ_READY === 1'h0, "ready without card");
        chk((&{MEM_RD_N, MEM_WR_N, IO_RD_N, IO_WR_N}) | STROBE_OE_N, "strobes");
        $display("test remove done");
    endtask
    initial begin
        repeat (5) @(posedge CLK);
        SRST <= 1'h0;
        t_power;
        cyc(1'h0, 1'h0, 1'h1, 5'h0);
        cyc(1'h0, 1'h1, 1'h0, 5'h0);
        cyc(1'h1, 1'h0, 1'h0, 5'h0);
        cyc(1'h1, 1'h1, 1'h0, 5'h0);
        cyc(1'h0, 1'h0, 1'h0, 5'ha);
        t_vpp;
        t_remove;
        final_report;
    end
endmodule // pcss_socket_tb
bind pcss_socket pcss_socket_checker chk_u (.*);
